//--- disp_timing_pkg.sv
package disp_timing_pkg;
    // command codes on the command write port
    localparam logic [3:0] CMD_POWER = 4'h1;
    localparam logic [3:0] CMD_CONTRAST = 4'h2;
    localparam logic [3:0] CMD_NLINE = 4'h3;
    localparam logic [3:0] CMD_COM_DIR = 4'h4;
    localparam logic [3:0] CMD_OSC_ON = 4'h5;
    localparam logic [3:0] CMD_DISPLAY = 4'h6;
    // values after reset
    localparam logic [2:0] POWER_RESET = 3'h0;
    localparam logic [5:0] CONTRAST_RESET = 6'h00;
    localparam logic [5:0] NLINE_RESET = 6'h00;
    localparam logic [5:0] CONTRAST_MAX = 6'h3F;
    // power field positions
    localparam int PWR_BOOST_BIT = 2;
    localparam int PWR_REG_BIT = 1;
    localparam int PWR_FOLLOW_BIT = 0;
    // internal oscillator timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int DCLK_PERIOD_NS = 32;
    localparam int OSC_HALF_CYCLES = (DCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    // drive level codes
    typedef enum logic [1:0] {LVL_LOW, LVL_MID_LOW, LVL_MID_HIGH, LVL_HIGH} drive_level_t;
    // config word layout: {display_on, com_reverse, master, nline}
    localparam int CFG_W = 9;
endpackage

//--- lcd_display_timing_ctrl.sv
// Overview of operation
// - Line timing is counted on the display clock and the latch output is held high; a slave also aligns line timing to the frame sync rising edge.
// - Each line's data is latched and driven out on the display clock.
// - Common scan, frame alternation and frame sync come from the display clock.
// - By default frame alternation flips once per frame.
// - Reversal value n-1 flips frame alternation every n lines.
// - Frame sync is a 50 percent square wave locked to the frame.
// - Master with internal oscillator drives all four timing pins.
// - Master with external clock takes the clock pin in, drives the rest.
// - Slave takes all four timing pins as inputs.
// - Common direction picks upward or downward common scan order.
// - Each output picks one of four levels from data, display-off and alternation.
// - Power block stays off in slave operation.
// - Three command bits enable booster, regulator and follower.
// - A six-bit contrast register holds 64 settings.
// - Contrast factor is 63 minus the register value.
// - Oscillator runs only as master, internal source, after oscillator-on.
`timescale 1ns/1ps
module lcd_display_timing_ctrl #(
    parameter int COMMONS = 64,
    parameter int SEGS = 8
) (
    // system clock domain
    input wire logic clk,
    input wire logic rstn,
    // display clock domain
    input wire logic disp_clk,
    // mode straps
    input wire logic master_sel,
    input wire logic clock_source_select,
    // command write port
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [7:0] cmd_data,
    // line data from display memory
    input wire logic [SEGS-1:0] line_data,
    // timing pins
    input wire logic frame_alternation_signal_in,
    output logic frame_alternation_signal_out,
    output logic frame_alternation_signal_oe_n,
    input wire logic frame_sync_in,
    output logic frame_sync_out,
    output logic frame_sync_oe_n,
    output logic display_clock_pin_out,
    output logic display_clock_pin_oe_n,
    input wire logic display_off_signal_in,
    output logic display_off_signal_out,
    output logic display_off_signal_oe_n,
    // line timing
    output logic [$clog2(COMMONS)-1:0] line_addr,
    output logic latch_pulse,
    output logic [$clog2(COMMONS)-1:0] common_output,
    output logic [1:0] common_level,
    output logic [2*SEGS-1:0] segment_output,
    // power and contrast
    output logic [2:0] power_enable,
    output logic [5:0] contrast_factor
);
    import disp_timing_pkg::*;

    localparam int LW = $clog2(COMMONS);
    localparam logic [LW-1:0] LAST_LINE = LW'(COMMONS - 1);
    localparam logic [LW-1:0] HALF_LINE = LW'(COMMONS / 2);

    // system domain state
    logic master, ext_clk_sel;
    logic [2:0] power_block_enables, next_power_block_enables;
    logic [5:0] contrast_level, next_contrast_level;
    logic [5:0] nline_value, next_nline_value;
    logic com_reverse, next_com_reverse;
    logic osc_on, next_osc_on;
    logic display_on, next_display_on;
    logic [CFG_W-1:0] cfg_shadow, next_cfg_shadow;
    logic cfg_req, next_cfg_req;
    logic cfg_ack_sys;
    logic [$clog2(OSC_HALF_CYCLES+1)-1:0] osc_cnt, next_osc_cnt;
    logic osc_clk, next_osc_clk;
    logic [2:0] next_power_enable;
    logic [5:0] next_contrast_factor;
    logic [3:0] next_oe_n;
    logic [3:0] oe_n_q;
    logic [CFG_W-1:0] cfg_word;

    sync_2ff #(.WIDTH(2)) u_strap_sync (
        .clk(clk),
        .rstn(rstn),
        .d({master_sel, clock_source_select}),
        .q({master, ext_clk_sel})
    );

    assign cfg_word = {display_on, com_reverse, master, nline_value};

    always_comb
    begin
        next_power_block_enables = power_block_enables;
        next_contrast_level = contrast_level;
        next_nline_value = nline_value;
        next_com_reverse = com_reverse;
        next_osc_on = osc_on;
        next_display_on = display_on;
        if (cmd_valid)
        begin
            if (cmd_code == CMD_POWER)
                next_power_block_enables = cmd_data[2:0];
            else if (cmd_code == CMD_CONTRAST)
                next_contrast_level = cmd_data[5:0];
            else if (cmd_code == CMD_NLINE)
                next_nline_value = cmd_data[5:0];
            else if (cmd_code == CMD_COM_DIR)
                next_com_reverse = cmd_data[0];
            else if (cmd_code == CMD_OSC_ON)
                next_osc_on = cmd_data[0];
            else if (cmd_code == CMD_DISPLAY)
                next_display_on = cmd_data[0];
        end
        next_power_enable = master ? power_block_enables : 3'h0;
        next_contrast_factor = CONTRAST_MAX - contrast_level;
        // config word crosses by toggle handshake, one word in flight
        next_cfg_shadow = cfg_shadow;
        next_cfg_req = cfg_req;
        if ((cfg_req == cfg_ack_sys) && (cfg_word != cfg_shadow))
        begin
            next_cfg_shadow = cfg_word;
            next_cfg_req = ~cfg_req;
        end
        next_osc_cnt = osc_cnt;
        next_osc_clk = osc_clk;
        if (master && ext_clk_sel && osc_on)
        begin
            if (osc_cnt == ($bits(osc_cnt))'(OSC_HALF_CYCLES - 1))
            begin
                next_osc_cnt = '0;
                next_osc_clk = ~osc_clk;
            end
            else
                next_osc_cnt = osc_cnt + 1'b1;
        end
        else
        begin
            next_osc_cnt = '0;
            next_osc_clk = 1'b0;
        end
        // pin directions: fr, sync, clock, display-off
        next_oe_n[3] = ~master;
        next_oe_n[2] = ~master;
        next_oe_n[1] = ~(master && ext_clk_sel);
        next_oe_n[0] = ~master;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_block_enables <= POWER_RESET;
            contrast_level <= CONTRAST_RESET;
            nline_value <= NLINE_RESET;
            com_reverse <= 1'b0;
            osc_on <= 1'b0;
            display_on <= 1'b0;
            cfg_shadow <= '0;
            cfg_req <= 1'b0;
            osc_cnt <= '0;
            osc_clk <= 1'b0;
            power_enable <= 3'h0;
            contrast_factor <= CONTRAST_MAX;
            oe_n_q <= 4'hF;
        end
        else
        begin
            power_block_enables <= next_power_block_enables;
            contrast_level <= next_contrast_level;
            nline_value <= next_nline_value;
            com_reverse <= next_com_reverse;
            osc_on <= next_osc_on;
            display_on <= next_display_on;
            cfg_shadow <= next_cfg_shadow;
            cfg_req <= next_cfg_req;
            osc_cnt <= next_osc_cnt;
            osc_clk <= next_osc_clk;
            power_enable <= next_power_enable;
            contrast_factor <= next_contrast_factor;
            oe_n_q <= next_oe_n;
        end
    end

    assign frame_alternation_signal_oe_n = oe_n_q[3];
    assign frame_sync_oe_n = oe_n_q[2];
    assign display_clock_pin_oe_n = oe_n_q[1];
    assign display_off_signal_oe_n = oe_n_q[0];
    assign display_clock_pin_out = osc_clk;

    // display clock domain state
    logic req_d, req_seen, next_req_seen;
    logic [CFG_W-1:0] cfg_d, next_cfg_d;
    logic fr_pin, sync_pin, dof_pin;
    logic sync_pin_q, next_sync_pin_q;
    logic [LW-1:0] line_cnt, next_line_cnt;
    logic [5:0] nline_cnt, next_nline_cnt;
    logic fr_int, next_fr_int;
    logic next_fr_out, next_sync_out, next_dof_out;
    logic [LW-1:0] next_line_addr, next_common;
    logic next_latch;
    logic [SEGS-1:0] seg_data, next_seg_data;
    logic [1:0] next_common_level;
    logic [2*SEGS-1:0] next_segment_output;
    logic d_master, d_reverse, d_on, fr_use, blank;
    logic [5:0] d_nline;
    logic frame_end, sync_rise;

    sync_2ff #(.WIDTH(4)) u_disp_sync (
        .clk(disp_clk),
        .rstn(rstn),
        .d({cfg_req, frame_alternation_signal_in, frame_sync_in, display_off_signal_in}),
        .q({req_d, fr_pin, sync_pin, dof_pin})
    );

    sync_2ff #(.WIDTH(1)) u_ack_sync (
        .clk(clk),
        .rstn(rstn),
        .d(req_seen),
        .q(cfg_ack_sys)
    );

    assign {d_on, d_reverse, d_master, d_nline} = cfg_d;

    always_comb
    begin
        next_req_seen = req_d;
        next_cfg_d = (req_d != req_seen) ? cfg_shadow : cfg_d;
        next_sync_pin_q = sync_pin;
        sync_rise = sync_pin && !sync_pin_q;
        frame_end = (line_cnt == LAST_LINE);
        // line counter on display clock; slave aligns to sync edge
        if (!d_master && sync_rise)
            next_line_cnt = '0;
        else if (frame_end)
            next_line_cnt = '0;
        else
            next_line_cnt = line_cnt + 1'b1;
        next_nline_cnt = nline_cnt;
        next_fr_int = fr_int;
        if (d_nline == 6'h00)
        begin
            next_nline_cnt = '0;
            if (frame_end)
                next_fr_int = ~fr_int;
        end
        else if (frame_end || (!d_master && sync_rise))
        begin
            next_nline_cnt = '0;
            next_fr_int = ~fr_int;
        end
        else if (nline_cnt == d_nline)
        begin
            next_nline_cnt = '0;
            next_fr_int = ~fr_int;
        end
        else
            next_nline_cnt = nline_cnt + 1'b1;
        // sync high for first half of frame
        next_sync_out = (next_line_cnt < HALF_LINE);
        next_fr_out = next_fr_int;
        next_dof_out = d_on;
        // slave uses pin alternation and display-off
        fr_use = d_master ? fr_int : fr_pin;
        blank = d_master ? !d_on : !dof_pin;
        // latch line data at each line start
        next_latch = 1'b1;
        next_seg_data = line_data;
        next_line_addr = line_cnt;
        next_common = d_reverse ? (LAST_LINE - line_cnt) : line_cnt;
        // four-level select from data, display-off and alternation
        next_common_level = fr_use ? LVL_LOW : LVL_HIGH;
        for (int i = 0; i < SEGS; i++)
        begin
            if ((seg_data[i] && !blank) ^ fr_use)
                next_segment_output[2*i +: 2] = LVL_MID_HIGH;
            else
                next_segment_output[2*i +: 2] = LVL_MID_LOW;
        end
    end

    always_ff @(posedge disp_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_seen <= 1'b0;
            cfg_d <= '0;
            sync_pin_q <= 1'b0;
            line_cnt <= '0;
            nline_cnt <= '0;
            fr_int <= 1'b0;
            frame_alternation_signal_out <= 1'b0;
            frame_sync_out <= 1'b0;
            display_off_signal_out <= 1'b0;
            latch_pulse <= 1'b0;
            seg_data <= '0;
            line_addr <= '0;
            common_output <= '0;
            common_level <= LVL_HIGH;
            segment_output <= '0;
        end
        else
        begin
            req_seen <= next_req_seen;
            cfg_d <= next_cfg_d;
            sync_pin_q <= next_sync_pin_q;
            line_cnt <= next_line_cnt;
            nline_cnt <= next_nline_cnt;
            fr_int <= next_fr_int;
            frame_alternation_signal_out <= next_fr_out;
            frame_sync_out <= next_sync_out;
            display_off_signal_out <= next_dof_out;
            latch_pulse <= next_latch;
            seg_data <= next_seg_data;
            line_addr <= next_line_addr;
            common_output <= next_common;
            common_level <= next_common_level;
            segment_output <= next_segment_output;
        end
    end
endmodule // lcd_display_timing_ctrl

//--- lcd_display_timing_ctrl_chk.sv
`timescale 1ns/1ps
module lcd_timing_chk #(
    parameter int COMMONS = 64
) (
    // clocks
    input wire logic clk,
    input wire logic rstn,
    input wire logic disp_clk,
    // controls
    input wire logic master_sel,
    input wire logic clock_source_select,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [7:0] cmd_data,
    // watched outputs
    input wire logic frame_alternation_signal_oe_n,
    input wire logic frame_sync_oe_n,
    input wire logic display_clock_pin_oe_n,
    input wire logic display_off_signal_oe_n,
    input wire logic display_clock_pin_out,
    input wire logic frame_sync_out,
    input wire logic [2:0] power_enable,
    input wire logic [5:0] contrast_factor
);
    import disp_timing_pkg::*;
    logic [3:0] oe;
    int hi;
    logic fell_seen;
    assign oe = {frame_alternation_signal_oe_n, frame_sync_oe_n, display_clock_pin_oe_n,
        display_off_signal_oe_n};
    // length of the current high phase of frame sync
    always_ff @(posedge disp_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hi <= 0;
            fell_seen <= 1'b0;
        end
        else
        begin
            hi <= frame_sync_out ? hi + 1 : 0;
            fell_seen <= fell_seen || $fell(frame_sync_out);
        end
    end
    contrast_factor_a: assert property (@(posedge clk) disable iff (!rstn)
        cmd_valid && cmd_code == CMD_CONTRAST |-> ##2 contrast_factor == 6'h3F - $past(cmd_data[5:0], 2))
        else $error("contrast factor wrong");
    power_cmd_a: assert property (@(posedge clk) disable iff (!rstn)
        master_sel [*4] ##0 (cmd_valid && cmd_code == CMD_POWER) |-> ##2 power_enable == $past(cmd_data[2:0], 2))
        else $error("power enables wrong");
    slave_power_a: assert property (@(posedge clk) disable iff (!rstn)
        !master_sel [*5] |-> power_enable == 3'h0) else $error("power on in slave");
    slave_pins_a: assert property (@(posedge clk) disable iff (!rstn)
        !master_sel [*5] |-> oe == 4'hF) else $error("slave drives a pin");
    ext_pins_a: assert property (@(posedge clk) disable iff (!rstn)
        (master_sel && !clock_source_select) [*5] |-> oe == 4'h2) else $error("external mode pins");
    int_pins_a: assert property (@(posedge clk) disable iff (!rstn)
        (master_sel && clock_source_select) [*5] |-> oe == 4'h0) else $error("internal mode pins");
    osc_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !(master_sel && clock_source_select) [*5] |-> !display_clock_pin_out) else $error("clock runs");
    osc_half_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(display_clock_pin_out) |-> display_clock_pin_out [*4] ##1 !display_clock_pin_out)
        else $error("clock half period wrong");
    sync_duty_a: assert property (@(posedge disp_clk) disable iff (!rstn || !master_sel)
        $fell(frame_sync_out) && fell_seen |-> hi == COMMONS / 2) else $error("sync duty wrong");
    cover property (@(posedge clk) disable iff (!rstn) cmd_valid && cmd_code == CMD_POWER);
    cover property (@(posedge clk) disable iff (!rstn) $rose(display_clock_pin_out));
    cover property (@(posedge disp_clk) disable iff (!rstn) $fell(frame_sync_out) && fell_seen);
endmodule // lcd_timing_chk

bind lcd_display_timing_ctrl lcd_timing_chk #(.COMMONS(COMMONS)) chk (.clk(clk), .rstn(rstn),
    .disp_clk(disp_clk), .master_sel(master_sel), .clock_source_select(clock_source_select),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .frame_alternation_signal_oe_n(frame_alternation_signal_oe_n), .frame_sync_oe_n(frame_sync_oe_n),
    .display_clock_pin_oe_n(display_clock_pin_oe_n), .display_off_signal_oe_n(display_off_signal_oe_n),
    .display_clock_pin_out(display_clock_pin_out), .frame_sync_out(frame_sync_out),
    .power_enable(power_enable), .contrast_factor(contrast_factor));

//--- peer_master_model.sv
`timescale 1ns/1ps
module peer_master_model #(
    parameter int LINES = 64
) (
    // display clock and reset
    input wire logic disp_clk,
    input wire logic rstn,
    // timing pins fed to the slave
    output logic fr,
    output logic sync,
    output logic display_off_signal
);
    int line;
    assign display_off_signal = 1'b1;
    always_ff @(posedge disp_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            line <= 0;
            fr <= 1'b0;
            sync <= 1'b0;
        end
        else
        begin
            line <= (line + 1) % LINES;
            sync <= (line + 1) % LINES < LINES / 2;
            fr <= fr ^ (line == LINES - 1);
        end
    end
endmodule // peer_master_model

//--- sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // destination clock and reset
    input wire logic clk,
    input wire logic rstn,
    // level in, synchronised level out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync_2ff

//--- tb_lcd_display_timing_ctrl.sv
`timescale 1ns/1ps
module tb_lcd_display_timing_ctrl;
    import disp_timing_pkg::*;
    logic clk, rstn, disp_clk, master_sel, clock_source_select, cmd_valid, latch_pulse;
    logic frame_alternation_signal_in, frame_alternation_signal_out, frame_alternation_signal_oe_n;
    logic frame_sync_in, frame_sync_out, frame_sync_oe_n, display_clock_pin_out, display_clock_pin_oe_n;
    logic display_off_signal_in, display_off_signal_out, display_off_signal_oe_n;
    logic [3:0] cmd_code;
    logic [7:0] cmd_data, line_data;
    logic [5:0] line_addr, common_output, contrast_factor, v;
    logic [1:0] common_level;
    logic [15:0] segment_output;
    logic [2:0] power_enable;
    logic [31:0] seed = 32'h0B73, r;
    int fails = 0, n_compared = 0, ks[3] = '{0, 4, 1};
    lcd_display_timing_ctrl dut (.*);
    peer_master_model peer (.disp_clk(disp_clk), .rstn(rstn), .fr(frame_alternation_signal_in),
        .sync(frame_sync_in), .display_off_signal(display_off_signal_in));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        disp_clk = 1'b0;
        #1.3;
        forever #16 disp_clk = ~disp_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] sexp(input logic a);
        logic [15:0] s;
        for (int i = 0; i < 8; i++)
            s[2*i +: 2] = (line_data[i] ^ a) ? LVL_MID_HIGH : LVL_MID_LOW;
        return s;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] d);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        step(1);
        cmd_valid = 1'b0;
        step(1);
    endtask
    task automatic osc(input int e);
        int n = 0;
        logic p = display_clock_pin_out;
        repeat (40)
        begin
            step(1);
            n += int'(display_clock_pin_out && !p);
            p = display_clock_pin_out;
        end
        chk("osc_rises", e, n);
    endtask
    // watches two frames: line and common stepping, alternation spacing, drive levels
    task automatic mon(input int k, input logic rev, input logic slv);
        int n, tog, lf, q[$];
        logic [5:0] el, ec;
        logic [7:0] f;
        n = (k == 0) ? 64 : k + 1;
        tog = 0;
        lf = 0;
        #1;
        r = rnd();
        line_data = r[7:0];
        @(posedge disp_clk);
        #1;
        f = {8{slv ? frame_alternation_signal_in : frame_alternation_signal_out}};
        for (int i = 0; i < 128; i++)
        begin
            el = line_addr + 6'h01;
            ec = rev ? common_output - 6'h01 : common_output + 6'h01;
            @(posedge disp_clk);
            #1;
            f = {f[6:0], slv ? frame_alternation_signal_in : frame_alternation_signal_out};
            chk("line_addr", el, line_addr);
            chk("common", ec, common_output);
            chk("frame_sync", (el + 6'h01) < 6'h20, frame_sync_out);
            chk("latch", 1'b1, latch_pulse);
            lf++;
            if (f[1] != f[0])
            begin
                if (tog > 0)
                    q.push_back(lf);
                tog++;
                lf = 0;
            end
            if (((f ^ {8{f[0]}}) & (slv ? 8'hFF : 8'h0F)) == 8'h00)
            begin
                chk("common_level", f[0] ? LVL_LOW : LVL_HIGH, common_level);
                chk("segment", sexp(f[0]), segment_output);
            end
        end
        if (!slv)
        begin
            chk("toggles", 2 * (63 / n + 1), tog);
            foreach (q[j])
                chk("interval", q[j] == n ? n : 64 - n * (63 / n), q[j]);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #150000;
        fails++;
        final_report();
    end
    initial
    begin
        rstn = 1'b0;
        master_sel = 1'b0;
        clock_source_select = 1'b0;
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_data = 8'h00;
        line_data = 8'h00;
        step(20);
        rstn = 1'b1;
        step(5);
        cmd(CMD_POWER, 8'h07);
        step(3);
        chk("power_slave", 3'h0, power_enable);
        repeat (150) @(posedge disp_clk);
        mon(0, 1'b0, 1'b1);
        step(1);
        for (int i = 0; i < 4; i++)
        begin
            {master_sel, clock_source_select} = i[1:0];
            step(5);
            chk("pin_dirs", i < 2 ? 4'hF : (i == 2 ? 4'h2 : 4'h0), {frame_alternation_signal_oe_n,
                frame_sync_oe_n, display_clock_pin_oe_n, display_off_signal_oe_n});
        end
        osc(0);
        rstn = 1'b0;
        step(20);
        rstn = 1'b1;
        step(5);
        for (int i = 0; i < 10; i++)
        begin
            r = rnd();
            v = i == 0 ? 6'h00 : (i == 1 ? 6'h3F : r[5:0]);
            cmd(CMD_CONTRAST, {2'b00, v});
            chk("contrast", 6'h3F - v, contrast_factor);
        end
        for (int p = 0; p < 8; p++)
        begin
            cmd(CMD_POWER, p[7:0]);
            chk("power", p[2:0], power_enable);
        end
        cmd(CMD_OSC_ON, 8'h01);
        step(4);
        osc(5);
        chk("display_off", 1'b0, display_off_signal_out);
        cmd(CMD_DISPLAY, 8'h01);
        for (int t = 0; t < 3; t++)
        begin
            step(1);
            cmd(CMD_NLINE, ks[t][7:0]);
            cmd(CMD_COM_DIR, {7'h00, t == 1});
            repeat (150) @(posedge disp_clk);
            mon(ks[t], t == 1, 1'b0);
        end
        chk("display_on", 1'b1, display_off_signal_out);
        final_report();
    end
endmodule // tb_lcd_display_timing_ctrl
